// ---- rtl/sfc_synth_ctrl.sv ----
// Purpose: frequency control and settle sequencing of the fractional-N synthesizer
// Assumes: 10 MHz reference as clock, host on the plain register port
// Notes: outputs are registered and trail the internal state by one cycle, synth_divide by two
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sfc_synth_ctrl #(
	parameter logic [7:0] DEV_STEP = sfc_pkg::DEV_STEP_RESET
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic tx_data,
	output logic pll_enable,
	output logic bias_settling,
	output logic vco_cal_run,
	output logic loop_settling,
	output logic synth_settled,
	output logic tx_active,
	output logic rx_active,
	output logic lo_div2,
	output sfc_pkg::sfc_div_t division,
	output logic [7:0] synth_divide
);
	localparam int TW = sfc_pkg::TIMER_W;
	localparam logic signed [17:0] MOD_S = 18'(sfc_pkg::DSM_MODULUS);

	// ************************************************************
	// register file
	// ************************************************************
	logic [7:0] trim_low;
	logic [sfc_pkg::TRIM_HIGH_MSB:0] trim_high;
	logic band_side;
	logic band_high;
	logic [sfc_pkg::FB_MSB:0] band_int;
	logic [7:0] frac_high;
	logic [7:0] frac_low;
	sfc_pkg::sfc_ctrl_t ctrl;
	logic freq_write;
	logic [15:0] carrier_frac;
	logic signed [9:0] trim;

	function automatic logic [4:0] clamp_int(input logic [4:0] v);
		return (v > sfc_pkg::FB_MAX) ? sfc_pkg::FB_MAX : v;
	endfunction

	function automatic logic is_freq_reg(input logic [7:0] a);
		return (a >= sfc_pkg::ADDR_TRIM_LOW) && (a <= sfc_pkg::ADDR_FRAC_LOW);
	endfunction

	assign carrier_frac = {frac_high, frac_low};
	assign trim = signed'({trim_high, trim_low});
	assign freq_write = reg_write && is_freq_reg(reg_addr);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			trim_low <= sfc_pkg::TRIM_LOW_RESET;
			trim_high <= sfc_pkg::TRIM_HIGH_RESET[sfc_pkg::TRIM_HIGH_MSB:0];
			band_side <= sfc_pkg::BAND_RESET[sfc_pkg::SB_BIT];
			band_high <= sfc_pkg::BAND_RESET[sfc_pkg::HB_BIT];
			band_int <= sfc_pkg::BAND_RESET[sfc_pkg::FB_MSB:0];
			frac_high <= sfc_pkg::FRAC_HIGH_RESET;
			frac_low <= sfc_pkg::FRAC_LOW_RESET;
			ctrl <= sfc_pkg::CTRL_RESET;
		end else if (reg_write) begin
			case (reg_addr)
				sfc_pkg::ADDR_TRIM_LOW: begin
					trim_low <= reg_wdata;
				end
				sfc_pkg::ADDR_TRIM_HIGH: begin
					trim_high <= reg_wdata[sfc_pkg::TRIM_HIGH_MSB:0];
				end
				sfc_pkg::ADDR_BAND: begin
					band_side <= reg_wdata[sfc_pkg::SB_BIT];
					band_high <= reg_wdata[sfc_pkg::HB_BIT];
					band_int <= clamp_int(reg_wdata[sfc_pkg::FB_MSB:0]);
				end
				sfc_pkg::ADDR_FRAC_HIGH: begin
					frac_high <= reg_wdata;
				end
				sfc_pkg::ADDR_FRAC_LOW: begin
					frac_low <= reg_wdata;
				end
				sfc_pkg::ADDR_CTRL: begin
					ctrl <= reg_wdata[$bits(ctrl)-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	function automatic logic [7:0] read_mux(input logic [7:0] a);
		case (a)
			sfc_pkg::ADDR_TRIM_LOW: return trim_low;
			sfc_pkg::ADDR_TRIM_HIGH: return 8'(trim_high);
			sfc_pkg::ADDR_BAND: return {1'b0, band_side, band_high, band_int};
			sfc_pkg::ADDR_FRAC_HIGH: return frac_high;
			sfc_pkg::ADDR_FRAC_LOW: return frac_low;
			sfc_pkg::ADDR_CTRL: return 8'(ctrl);
			sfc_pkg::ADDR_STATUS: return {1'b0, loop_settling, bias_settling, pll_enable,
				vco_cal_run, rx_active, tx_active, synth_settled};
			default: return 8'h00;
		endcase
	endfunction

	// read data stand for exactly one cycle after the strobe
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_read ? read_mux(reg_addr) : 8'h00;
		end
	end

	// ************************************************************
	// modulation data input
	// ************************************************************
	logic data_meta;
	logic data_bit;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			data_meta <= 1'b0;
			data_bit <= 1'b0;
		end else begin
			data_meta <= tx_data;
			data_bit <= data_meta;
		end
	end

	// ************************************************************
	// mode sequencer
	// ************************************************************
	sfc_pkg::sfc_state_t state;
	logic [TW-1:0] timer;
	logic run_tx;
	logic run_rx;
	logic powerup_cal;
	logic want_tx;
	logic want_rx;
	logic go;
	logic restart;
	logic start;

	function automatic sfc_pkg::sfc_state_t next_step(input sfc_pkg::sfc_state_t s,
		input logic skip_cal, input logic running);
		case (s)
			sfc_pkg::st_bias: return skip_cal ? sfc_pkg::st_settle : sfc_pkg::st_cal;
			sfc_pkg::st_cal: return sfc_pkg::st_settle;
			sfc_pkg::st_settle: return running ? sfc_pkg::st_active : sfc_pkg::st_idle;
			default: return sfc_pkg::st_idle;
		endcase
	endfunction

	function automatic logic [TW-1:0] step_load(input sfc_pkg::sfc_state_t s);
		case (s)
			sfc_pkg::st_bias: return TW'(sfc_pkg::BIAS_CYC - 1);
			sfc_pkg::st_cal: return TW'(sfc_pkg::CAL_CYC - 1);
			sfc_pkg::st_settle: return TW'(sfc_pkg::LOOP_CYC - 1);
			default: return '0;
		endcase
	endfunction

	// transmit wins when software asks for both modes
	assign want_tx = ctrl.tx_on;
	assign want_rx = ctrl.rx_on && !ctrl.tx_on;
	assign go = want_tx || want_rx || powerup_cal;
	// a new frequency or a mode swap re-runs the whole tuning path
	assign restart = freq_write || ((state != sfc_pkg::st_idle)
		&& ((run_tx != want_tx) || (run_rx != want_rx)));
	assign start = ((state == sfc_pkg::st_idle) || restart) && go;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= sfc_pkg::st_idle;
			timer <= '0;
		end else if ((state == sfc_pkg::st_idle) || restart) begin
			if (go) begin
				// skipping bias also hands over to the skip-cal decision
				if (ctrl.skip_bias) begin
					state <= next_step(sfc_pkg::st_bias, ctrl.skip_cal, 1'b1);
					timer <= step_load(next_step(sfc_pkg::st_bias, ctrl.skip_cal, 1'b1));
				end else begin
					state <= sfc_pkg::st_bias;
					timer <= step_load(sfc_pkg::st_bias);
				end
			end else begin
				state <= sfc_pkg::st_idle;
				timer <= '0;
			end
		end else if (state != sfc_pkg::st_active) begin
			if (timer != '0) begin
				timer <= timer - TW'(1);
			end else begin
				state <= next_step(state, ctrl.skip_cal, run_tx || run_rx);
				timer <= step_load(next_step(state, ctrl.skip_cal, run_tx || run_rx));
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			run_tx <= 1'b0;
			run_rx <= 1'b0;
		end else if ((state == sfc_pkg::st_idle) || restart) begin
			run_tx <= go && want_tx;
			run_rx <= go && want_rx;
		end
	end

	// one tuning pass after reset even with no mode asked for
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			powerup_cal <= 1'b1;
		end else if (start) begin
			powerup_cal <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pll_enable <= 1'b0;
			bias_settling <= 1'b0;
			vco_cal_run <= 1'b0;
			loop_settling <= 1'b0;
			synth_settled <= 1'b0;
			tx_active <= 1'b0;
			rx_active <= 1'b0;
		end else begin
			pll_enable <= state != sfc_pkg::st_idle;
			bias_settling <= state == sfc_pkg::st_bias;
			vco_cal_run <= state == sfc_pkg::st_cal;
			loop_settling <= state == sfc_pkg::st_settle;
			synth_settled <= state == sfc_pkg::st_active;
			tx_active <= (state == sfc_pkg::st_active) && run_tx;
			rx_active <= (state == sfc_pkg::st_active) && run_rx;
		end
	end

	// ************************************************************
	// division ratio
	// ************************************************************
	logic signed [17:0] dev_s;
	logic signed [17:0] rx_s;
	logic signed [17:0] next_sum;
	logic [6:0] next_int;
	logic [15:0] next_frac;

	// deviation counts are coarser in low band, the loop runs at twice the ratio
	assign dev_s = signed'((18'(DEV_STEP) * 18'(sfc_pkg::DEV_UNIT)) >> band_high);
	// shift counts halve in high band since the output divider is bypassed
	assign rx_s = signed'(18'(sfc_pkg::RX_SHIFT_FRAC) >> band_high);

	always_comb begin
		next_sum = signed'({2'b00, carrier_frac}) + 18'(trim);
		if ((state == sfc_pkg::st_active) && run_tx) begin
			next_sum = data_bit ? next_sum + dev_s : next_sum - dev_s;
		end
		if (run_rx && (state != sfc_pkg::st_idle)) begin
			next_sum = next_sum - rx_s;
		end
		next_int = 7'(band_int) + 7'(sfc_pkg::N_OFFSET);
		// one correction suffices: trim, deviation and shift stay below the modulus
		if (next_sum < 0) begin
			next_frac = 16'(next_sum + MOD_S);
			next_int = next_int - 7'h01;
		end else if (next_sum >= MOD_S) begin
			next_frac = 16'(next_sum - MOD_S);
			next_int = next_int + 7'h01;
		end else begin
			next_frac = 16'(next_sum);
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			division <= '0;
			lo_div2 <= 1'b0;
		end else begin
			division.integer_part <= next_int;
			division.fraction <= next_frac;
			lo_div2 <= !band_high;
		end
	end

	// ************************************************************
	// modulator and instantaneous divide value
	// ************************************************************
	logic signed [3:0] dsm_offset;

	sfc_dsm #(
		.MODULUS(sfc_pkg::DSM_MODULUS),
		.W(16)
	) u_dsm (
		.clock(clock),
		.reset_n(reset_n),
		.enable(pll_enable),
		.fraction(division.fraction),
		.offset(dsm_offset)
	);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			synth_divide <= 8'h00;
		end else begin
			synth_divide <= 8'({1'b0, division.integer_part}) + 8'(dsm_offset);
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	localparam int CAL_REACH = sfc_pkg::BIAS_CYC + 2;
	localparam int TX_REACH = sfc_pkg::TOTAL_CYC + 3;
	logic [11:0] settle_run;
	logic [11:0] seq_run;
	logic [23:0] ratio_q;
	logic [23:0] base_q;
	logic [11:0] tx_wait;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			settle_run <= '0;
			seq_run <= '0;
			ratio_q <= '0;
			base_q <= '0;
			tx_wait <= '0;
		end else begin
			settle_run <= (state == sfc_pkg::st_settle) ? settle_run + 12'h001 : '0;
			seq_run <= start ? '0 : ((&seq_run) ? seq_run : seq_run + 12'h001);
			ratio_q <= 24'(next_int) * 24'(sfc_pkg::DSM_MODULUS) + 24'(next_frac);
			base_q <= (24'(band_int) + 24'(sfc_pkg::N_OFFSET)) * 24'(sfc_pkg::DSM_MODULUS)
				+ 24'(carrier_frac) + 24'(trim);
			// cycles spent waiting for transmit; any write restarts the wait
			tx_wait <= (reg_write || tx_active || !ctrl.tx_on) ? '0
				: ((&tx_wait) ? tx_wait : tx_wait + 12'h001);
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	property p_clamp;
		reg_write && (reg_addr == sfc_pkg::ADDR_BAND)
			&& (reg_wdata[sfc_pkg::FB_MSB:0] > sfc_pkg::FB_MAX) |=> band_int == sfc_pkg::FB_MAX;
	endproperty
	a_clamp: assert property (p_clamp) else $error("band integer not clamped");

	property p_unused_zero;
		reg_read && (reg_addr == sfc_pkg::ADDR_TRIM_HIGH || reg_addr == sfc_pkg::ADDR_BAND)
			|=> !reg_rdata[7] && (reg_addr != sfc_pkg::ADDR_TRIM_HIGH || reg_rdata[7:2] == '0);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");

	property p_recal;
		freq_write && !ctrl.skip_bias && !ctrl.skip_cal && go
			|-> ##[1:CAL_REACH] (vco_cal_run || reg_write);
	endproperty
	a_recal: assert property (p_recal) else $error("no calibration after change");

	property p_loop_len;
		(state == sfc_pkg::st_active) && ($past(state) == sfc_pkg::st_settle)
			|-> $past(settle_run) == 12'(sfc_pkg::LOOP_CYC - 1);
	endproperty
	a_loop_len: assert property (p_loop_len) else $error("loop settle length wrong");

	property p_total;
		(state == sfc_pkg::st_active) && ($past(state) != sfc_pkg::st_active)
			|-> seq_run <= 12'(sfc_pkg::TOTAL_CYC);
	endproperty
	a_total: assert property (p_total) else $error("tuning exceeded total time");

	property p_skip_cal;
		(state == sfc_pkg::st_cal) && ($past(state) != sfc_pkg::st_cal) |-> !$past(ctrl.skip_cal);
	endproperty
	a_skip_cal: assert property (p_skip_cal) else $error("calibration not skipped");

	property p_skip_bias;
		start && ctrl.skip_bias |=> state != sfc_pkg::st_bias;
	endproperty
	a_skip_bias: assert property (p_skip_bias) else $error("bias settle not skipped");

	property p_seq_tx;
		tx_wait <= 12'(TX_REACH);
	endproperty
	a_seq_tx: assert property (p_seq_tx) else $error("transmit never reached");

	property p_ratio;
		!pll_enable |-> ratio_q == base_q;
	endproperty
	a_ratio: assert property (p_ratio) else $error("division ratio wrong");

	property p_rx_shift;
		rx_active |-> base_q - ratio_q == (lo_div2 ? 24'(sfc_pkg::RX_SHIFT_FRAC)
			: 24'(sfc_pkg::RX_SHIFT_FRAC >> 1));
	endproperty
	a_rx_shift: assert property (p_rx_shift) else $error("receive shift wrong");

	property p_band;
		reg_write && (reg_addr == sfc_pkg::ADDR_BAND)
			|-> ##2 lo_div2 == !$past(reg_wdata[sfc_pkg::HB_BIT], 2);
	endproperty
	a_band: assert property (p_band) else $error("output divider wrong");

	c_tx_lock: cover property ($rose(tx_active));
	c_rx_lock: cover property ($rose(rx_active));
	c_fast_turn: cover property (start && ctrl.skip_bias && ctrl.skip_cal);
	c_retune: cover property (synth_settled && freq_write);
endmodule
`default_nettype wire

// ---- rtl/sfc_pkg.sv ----
// Purpose: shared constants and types for the synthesizer frequency control
// Assumes: 10 MHz reference clock, 8-bit register port
// Notes: offsets are byte addresses on the register port
package sfc_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] ADDR_TRIM_LOW = 8'h73;
	localparam logic [7:0] ADDR_TRIM_HIGH = 8'h74;
	localparam logic [7:0] ADDR_BAND = 8'h75;
	localparam logic [7:0] ADDR_FRAC_HIGH = 8'h76;
	localparam logic [7:0] ADDR_FRAC_LOW = 8'h77;
	localparam logic [7:0] ADDR_CTRL = 8'h78;
	localparam logic [7:0] ADDR_STATUS = 8'h7b;
	localparam logic [7:0] TRIM_LOW_RESET = 8'h00;
	localparam logic [7:0] TRIM_HIGH_RESET = 8'h00;
	localparam logic [7:0] BAND_RESET = 8'h35;
	localparam logic [7:0] FRAC_HIGH_RESET = 8'hbb;
	localparam logic [7:0] FRAC_LOW_RESET = 8'h80;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam int FB_MSB = 4;
	localparam int HB_BIT = 5;
	localparam int SB_BIT = 6;
	localparam int TRIM_HIGH_MSB = 1;
	localparam logic [4:0] FB_MAX = 5'h17;
	// ************************************************************
	// division ratio arithmetic
	// ************************************************************
	localparam int N_OFFSET = 24;
	localparam int DSM_MODULUS = 64000;
	localparam int REF_HZ = 10000000;
	localparam int RX_SHIFT_HZ = 937500;
	localparam longint RX_SHIFT_FRAC = 64'(RX_SHIFT_HZ) * DSM_MODULUS / REF_HZ;
	localparam int DEV_UNIT = 4;
	localparam logic [7:0] DEV_STEP_RESET = 8'h20;
	// ************************************************************
	// sequencer timing
	// ************************************************************
	localparam int CLK_NS = 100;
	localparam int BIAS_NS = 50000;
	localparam int CAL_NS = 50000;
	localparam int LOOP_NS = 100000;
	localparam int TOTAL_NS = 200000;
	localparam int BIAS_CYC = (BIAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int CAL_CYC = (CAL_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOOP_CYC = (LOOP_NS + CLK_NS - 1) / CLK_NS;
	localparam int TOTAL_CYC = TOTAL_NS / CLK_NS;
	localparam int TIMER_W = 11;
	typedef enum {st_idle, st_bias, st_cal, st_settle, st_active} sfc_state_t;
	typedef struct packed {
		logic skip_bias;
		logic skip_cal;
		logic rx_on;
		logic tx_on;
	} sfc_ctrl_t;
	typedef struct packed {
		logic [6:0] integer_part;
		logic [15:0] fraction;
	} sfc_div_t;
endpackage

// ---- rtl/sfc_dsm.sv ----
// Purpose: third order delta-sigma modulator for the feedback divider
// Assumes: fraction below the modulus, clocked by the reference
// Notes: three cascaded first order stages, carries recombined
`timescale 1ns/10ps
`default_nettype none
module sfc_dsm #(
	parameter int MODULUS = sfc_pkg::DSM_MODULUS,
	parameter int W = 16
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic [W-1:0] fraction,
	output logic signed [3:0] offset
);
	// ************************************************************
	// accumulator stages
	// ************************************************************
	localparam logic [W:0] MOD_W = (W+1)'(MODULUS);
	logic [W-1:0] acc [3];
	logic [2:0] carry;
	logic c2_d, c3_d, c3_dd;

	genvar k;
	generate
		for (k = 0; k < 3; k++) begin : g_stage
			logic [W:0] sum;
			if (k == 0) begin : g_in
				assign sum = {1'b0, fraction} + {1'b0, acc[0]};
			end else begin : g_chain
				assign sum = {1'b0, acc[k-1]} + {1'b0, acc[k]};
			end
			// wrap at the modulus, the carry is the stage output
			assign carry[k] = (sum >= MOD_W);
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					acc[k] <= '0;
				end else if (!enable) begin
					acc[k] <= '0;
				end else begin
					acc[k] <= carry[k] ? W'(sum - MOD_W) : W'(sum);
				end
			end
		end
	endgenerate

	// ************************************************************
	// noise shaping recombination
	// ************************************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			c2_d <= 1'b0;
			c3_d <= 1'b0;
			c3_dd <= 1'b0;
			offset <= '0;
		end else begin
			c2_d <= enable & carry[1];
			c3_d <= enable & carry[2];
			c3_dd <= c3_d;
			offset <= enable ? 4'(signed'({3'b000, carry[0]}) + signed'({3'b000, carry[1]})
				- signed'({3'b000, c2_d}) + signed'({3'b000, carry[2]})
				- signed'({2'b00, c3_d, 1'b0}) + signed'({3'b000, c3_dd})) : 4'h0;
		end
	end

	property p_acc_range;
		@(posedge clock) disable iff (!reset_n)
		({1'b0, acc[0]} < MOD_W) && ({1'b0, acc[1]} < MOD_W) && ({1'b0, acc[2]} < MOD_W);
	endproperty
	a_acc_range: assert property (p_acc_range) else $error("accumulator past modulus");
endmodule
`default_nettype wire

// ---- test/sfc_host_model.sv ----
// Purpose: host model that drives the register port of the synthesizer control
// Assumes: one clock, strobes one cycle long, read data the cycle after the strobe
// Notes: the bench calls the tasks; data is inverted once released
`timescale 1ns/10ps
`default_nettype none
module sfc_host_model (
	input wire logic clock,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	output logic reg_read,
	input wire logic [7:0] reg_rdata
);
	// ****************************************
	// register port cycles
	// ****************************************
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		d = reg_rdata;
	endtask
	// hot low band fix-up; these places are not decoded by this block
	task automatic hot_low_band();
		wr(8'h59, 8'h03);
		wr(8'h5a, 8'h02);
	endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Purpose: self-checking bench for the synthesizer frequency control
// Assumes: 10 MHz clock, host model on the register port
// Notes: random band, fraction and trim from a fixed lfsr seed
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam int DEV = 32;
	logic clock, reset_n, tx_data, reg_write, reg_read;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, synth_divide, rd_val, band;
	logic pll_enable, bias_settling, vco_cal_run, loop_settling;
	logic synth_settled, tx_active, rx_active, lo_div2;
	sfc_pkg::sfc_div_t division;
	int failures, checked, n_bias, n_cal, n_loop, k, d;
	logic [15:0] seed, fc;
	logic [9:0] fo;
	logic [7:0] rst_tab [5] = '{8'h00, 8'h00, 8'h35, 8'hbb, 8'h80};
	sfc_synth_ctrl #(.DEV_STEP(8'(DEV))) uut (.clock(clock), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .tx_data(tx_data),
		.pll_enable(pll_enable), .bias_settling(bias_settling), .vco_cal_run(vco_cal_run),
		.loop_settling(loop_settling), .synth_settled(synth_settled), .tx_active(tx_active),
		.rx_active(rx_active), .lo_div2(lo_div2), .division(division),
		.synth_divide(synth_divide));
	sfc_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic sfc_pkg::sfc_div_t exp_div(input logic [7:0] b, input logic [15:0] c,
		input logic [9:0] o, input int dev, input bit rx);
		int f, n;
		sfc_pkg::sfc_div_t r;
		n = ((b[4:0] > 5'h17) ? 23 : int'(b[4:0])) + 24;
		f = int'(c) + int'($signed(o));
		f = f + dev * ((DEV * 4) >> b[5]) - (rx ? (6000 >> b[5]) : 0);
		if (f < 0) begin
			f += 64000;
			n--;
		end else if (f >= 64000) begin
			f -= 64000;
			n++;
		end
		r.integer_part = 7'(n);
		r.fraction = 16'(f);
		return r;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// counts each tuning step until settled, or until idle for the power-up pass
	task automatic tune(input int want_bias, input int want_cal, input bit to_idle);
		int i;
		logic [6:0] p;
		n_bias = 0;
		n_cal = 0;
		n_loop = 0;
		// the divide value is built from the ratio of the cycle before
		p = division.integer_part;
		for (i = 0; i < 2200; i++) begin
			@(negedge clock);
			// settled may still show the old pass for the first cycles
			if (i > 4 && (synth_settled === 1'b1 || (to_idle && pll_enable === 1'b0)))
				break;
			n_bias += int'(bias_settling === 1'b1);
			n_cal += int'(vco_cal_run === 1'b1);
			n_loop += int'(loop_settling === 1'b1);
			d = int'(synth_divide) - int'(p);
			p = division.integer_part;
			check(d >= -3 && d <= 4, 1, "modulator step");
		end
		check(n_bias, want_bias, "bias cycles");
		check(n_cal, want_cal, "calibration cycles");
		check(n_loop, 1000, "loop settle cycles");
		check(i <= 2002, 1, "tuning time");
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ****************************************
	// clock, watchdog and sequence
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		repeat (60000) @(posedge clock);
		failures++;
		$display("unexpected at %0t: run did not finish", $time);
		report_and_stop();
	end
	initial begin
		reset_n = 1'b0;
		tx_data = 1'b0;
		failures = 0;
		checked = 0;
		seed = 16'h0020;
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		tune(500, 500, 1);
		check(division, exp_div(8'h35, 16'hbb80, 10'h000, 0, 0), "reset ratio");
		check(lo_div2, 1'b0, "reset band divider");
		for (k = 0; k < 5; k++) begin
			host.rd(sfc_pkg::ADDR_TRIM_LOW + 8'(k), rd_val);
			check(rd_val, rst_tab[k], "reset value");
		end
		host.rd(sfc_pkg::ADDR_CTRL, rd_val);
		check(rd_val, 8'h00, "control reset");
		for (k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			band = (k == 0) ? 8'hff : (k == 1) ? 8'h17 : seed[7:0];
			fc = (seed >= 16'hfa00) ? seed - 16'hfa00 : seed;
			seed = lfsr(seed);
			fo = (k == 2) ? 10'h200 : seed[9:0];
			fc = (k == 2) ? 16'h0000 : (k == 3) ? 16'hf9ff : fc;
			fo = (k == 3) ? 10'h1ff : fo;
			host.wr(sfc_pkg::ADDR_BAND, band);
			host.wr(sfc_pkg::ADDR_TRIM_LOW, fo[7:0]);
			host.wr(sfc_pkg::ADDR_TRIM_HIGH, {6'h3f, fo[9:8]});
			host.wr(sfc_pkg::ADDR_FRAC_HIGH, fc[15:8]);
			host.wr(sfc_pkg::ADDR_FRAC_LOW, fc[7:0]);
			repeat (3) @(negedge clock);
			check(division, exp_div(band, fc, fo, 0, 0), "ratio");
			check(lo_div2, !band[5], "band divider");
			host.rd(sfc_pkg::ADDR_BAND, rd_val);
			check(rd_val, {1'b0, band[6:5], (band[4:0] > 5'h17) ? 5'h17 : band[4:0]}, "band");
			host.rd(sfc_pkg::ADDR_TRIM_HIGH, rd_val);
			check(rd_val, {6'h00, fo[9:8]}, "trim high");
		end
		for (k = 0; k < 8; k++) begin
			host.wr(sfc_pkg::ADDR_CTRL, 8'h00);
			repeat (3) @(posedge clock);
			host.wr(sfc_pkg::ADDR_CTRL, 8'({k[2:1], k[0], ~k[0]}));
			tune(k[2] ? 0 : 500, k[1] ? 0 : 500, 0);
			check(tx_active, !k[0], "transmit active");
			check(rx_active, k[0], "receive active");
			@(posedge clock);
			tx_data <= lfsr(seed) >= 16'h8000;
			seed = lfsr(seed);
			repeat (5) @(negedge clock);
			check(division, exp_div(band, fc, fo, k[0] ? 0 : (tx_data ? 1 : -1), k[0]), "tuned ratio");
		end
		host.wr(sfc_pkg::ADDR_CTRL, 8'h01);
		tune(500, 500, 0);
		host.rd(sfc_pkg::ADDR_STATUS, rd_val);
		check(rd_val, 8'h13, "status");
		host.hot_low_band();
		host.rd(8'h59, rd_val);
		check(rd_val, 8'h00, "unmapped read");
		check(synth_settled, 1'b1, "still settled");
		host.wr(sfc_pkg::ADDR_FRAC_LOW, fc[7:0] ^ 8'h01);
		tune(500, 500, 0);
		report_and_stop();
	end
endmodule
`default_nettype wire
